// ### inc/sks_params.svh
// Constants for the skip/increment execution block.
// Assumes inclusion by bare name from design files.
`ifndef SKS_PARAMS_SVH
`define SKS_PARAMS_SVH

`define SKS_DATA_W      8
`define SKS_ADDR_W      8
`define SKS_BITSEL_W    3
`define SKS_OPC_W       2
`define SKS_OPC_NONE    2'h0
`define SKS_OPC_INC_MEM 2'h1
`define SKS_OPC_INC_ACC 2'h2
`define SKS_OPC_BIT_SET 2'h3
`define SKS_INC_STEP    1
`define SKS_SKIP_CYCLES 3
`define SKS_ACC_RST     8'h00

`endif

// ### inc/sks_pkg.sv
// Types for the skip/increment execution block.
// Assumes sks_params.svh is on the include path.
`include "sks_params.svh"
package sks_pkg;
  typedef enum logic [1:0] {
    SKS_ST_IDLE,
    SKS_ST_READ,
    SKS_ST_EXEC,
    SKS_ST_DUMMY
  } sks_state_t;
endpackage

// ### rtl/sks_alu.sv
// Incrementer and bit tester for the skip instructions.
// Assumes purely combinational use by sks_core.
`timescale 1ns/10ps
`default_nettype none
`include "sks_params.svh"
module sks_alu
  import sks_pkg::*;
#(
  parameter int DATA_W = `SKS_DATA_W,
  parameter int BIT_W  = `SKS_BITSEL_W
) (
  input  wire logic [DATA_W-1:0] i_operand,
  input  wire logic [BIT_W-1:0]  i_bit_sel,
  output logic      [DATA_W-1:0] o_sum,
  output logic                   o_sum_zero,
  output logic                   o_bit_set
);
  // ==========================================================
  // Increment and test
  // ==========================================================
  // Sum truncated to the byte so all-ones wraps to zero [RULE_08]
  assign o_sum      = DATA_W'(i_operand + DATA_W'(`SKS_INC_STEP)); // [RULE_08]
  assign o_sum_zero = (o_sum == '0);
  assign o_bit_set  = i_operand[i_bit_sel];
endmodule
`default_nettype wire

// ### rtl/sks_core.sv
// Execution unit for increment-and-skip and bit-test-skip instructions.
// Assumes fetch presents one decoded op per i_op_valid pulse and waits for o_done;
// data memory answers reads one cycle after o_mem_rd.
// Contract
// [RULE_01] The memory variant adds one to the addressed byte and writes it back to the same address.
// [RULE_02] A zero result skips the instruction that follows in program order.
// [RULE_03] A skip inserts a dummy cycle during the next fetch, making the instruction three cycles long.
// [RULE_04] A non-zero result lets execution continue with the following instruction.
// [RULE_05] The accumulator variant loads the byte plus one into the accumulator and leaves memory untouched.
// [RULE_06] The accumulator variant skips when the new accumulator value is zero, with the same dummy cycle.
// [RULE_07] The bit-test variant skips when the selected bit of the addressed byte is one.
// [RULE_08] Increments wrap modulo the byte width, so the maximum value gives zero and skips.
`timescale 1ns/10ps
`default_nettype none
`include "sks_params.svh"
module sks_core
  import sks_pkg::*;
#(
  parameter int DATA_W = `SKS_DATA_W,
  parameter int ADDR_W = `SKS_ADDR_W,
  parameter int BIT_W  = `SKS_BITSEL_W
) (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_reset,
  input  wire logic                  i_clk_en,
  input  wire logic                  i_op_valid,
  input  wire logic [`SKS_OPC_W-1:0] i_opcode,
  input  wire logic [ADDR_W-1:0]     i_addr,
  input  wire logic [BIT_W-1:0]      i_bit_sel,
  input  wire logic [DATA_W-1:0]     i_mem_rdata,
  output logic                       o_busy,
  output logic                       o_mem_rd,
  output logic                       o_mem_wr,
  output logic      [ADDR_W-1:0]     o_mem_addr,
  output logic      [DATA_W-1:0]     o_mem_wdata,
  output logic      [DATA_W-1:0]     o_acc,
  output logic                       o_acc_wr,
  output logic                       o_skip,
  output logic                       o_dummy,
  output logic                       o_done
);
  if (DATA_W < 1 || BIT_W < 1 || (1 << BIT_W) > DATA_W || ADDR_W < 1) begin : g_chk
    $error("sks_core: unsupported parameter values");
  end

  // ==========================================================
  // State
  // ==========================================================
  sks_state_t              state_r, state_nxt;
  logic [`SKS_OPC_W-1:0]   opc_r;
  logic [BIT_W-1:0]        bit_r;
  logic [DATA_W-1:0]       sum_w;
  logic                    sum_zero_w;
  logic                    bit_set_w;

  sks_alu #(
    .DATA_W (DATA_W),
    .BIT_W  (BIT_W)
  ) u_alu (
    .i_operand  (i_mem_rdata),
    .i_bit_sel  (bit_r),
    .o_sum      (sum_w),
    .o_sum_zero (sum_zero_w),
    .o_bit_set  (bit_set_w)
  );

  // ==========================================================
  // Decode
  // ==========================================================
  wire logic is_mem_w  = (opc_r == `SKS_OPC_INC_MEM);
  wire logic is_acc_w  = (opc_r == `SKS_OPC_INC_ACC);
  wire logic is_bit_w  = (opc_r == `SKS_OPC_BIT_SET);
  wire logic start_w   = i_op_valid && (i_opcode != `SKS_OPC_NONE) && (state_r == SKS_ST_IDLE);
  wire logic exec_w    = (state_r == SKS_ST_EXEC);
  // True for the two increment variants
  function automatic logic opc_is_inc(input logic [`SKS_OPC_W-1:0] opc);
    return (opc == `SKS_OPC_INC_MEM) || (opc == `SKS_OPC_INC_ACC);
  endfunction

  // Zero sum skips for both increments, set bit skips bit test [RULE_02] [RULE_06] [RULE_07]
  wire logic skip_w    = (opc_is_inc(opc_r) && sum_zero_w) || (is_bit_w && bit_set_w);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SKS_ST_IDLE:  if (start_w) state_nxt = SKS_ST_READ;
      SKS_ST_READ:  state_nxt = SKS_ST_EXEC;
      // Skip adds the dummy cycle, otherwise finish [RULE_03] [RULE_04]
      SKS_ST_EXEC:  state_nxt = skip_w ? SKS_ST_DUMMY : SKS_ST_IDLE;
      SKS_ST_DUMMY: state_nxt = SKS_ST_IDLE;
      default:      state_nxt = SKS_ST_IDLE;
    endcase
  end

  // ==========================================================
  // Next values of the registered outputs
  // ==========================================================
  wire logic busy_nxt   = (state_nxt != SKS_ST_IDLE);
  wire logic rd_nxt     = start_w;
  wire logic wr_nxt     = exec_w && is_mem_w; // [RULE_01] [RULE_05]
  wire logic acc_wr_nxt = exec_w && is_acc_w; // [RULE_05]
  wire logic skip_nxt   = exec_w && skip_w; // [RULE_02] [RULE_06] [RULE_07]
  // Finished without a skip, or at the end of the dummy cycle
  wire logic done_nxt   = (exec_w && !skip_w) || (state_r == SKS_ST_DUMMY); // [RULE_03] [RULE_04]

  // ==========================================================
  // Sequencer state
  // ==========================================================
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_r <= SKS_ST_IDLE;
    end else if (i_clk_en) begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Captured instruction fields
  // ==========================================================
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      opc_r <= `SKS_OPC_NONE;
      bit_r <= '0;
    end else if (i_clk_en && start_w) begin
      opc_r <= i_opcode;
      bit_r <= i_bit_sel;
    end
  end

  // ==========================================================
  // Memory address
  // ==========================================================
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_mem_addr <= '0;
    end else if (i_clk_en && start_w) begin
      o_mem_addr <= i_addr; // [RULE_01]
    end
  end

  // ==========================================================
  // Strobes, one register each
  // ==========================================================
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_busy <= 1'b0;
    end else if (i_clk_en) begin
      o_busy <= busy_nxt;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_mem_rd <= 1'b0;
    end else if (i_clk_en) begin
      o_mem_rd <= rd_nxt;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_mem_wr <= 1'b0;
    end else if (i_clk_en) begin
      o_mem_wr <= wr_nxt; // [RULE_01] [RULE_05]
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_acc_wr <= 1'b0;
    end else if (i_clk_en) begin
      o_acc_wr <= acc_wr_nxt; // [RULE_05]
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_skip <= 1'b0;
    end else if (i_clk_en) begin
      o_skip <= skip_nxt; // [RULE_02] [RULE_06] [RULE_07]
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_dummy <= 1'b0;
    end else if (i_clk_en) begin
      o_dummy <= skip_nxt; // [RULE_03]
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_done <= 1'b0;
    end else if (i_clk_en) begin
      o_done <= done_nxt; // [RULE_03] [RULE_04]
    end
  end

  // ==========================================================
  // Write data
  // ==========================================================
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_mem_wdata <= '0;
    end else if (i_clk_en && wr_nxt) begin
      o_mem_wdata <= sum_w; // [RULE_01]
    end
  end

  // ==========================================================
  // Accumulator
  // ==========================================================
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_acc <= DATA_W'(`SKS_ACC_RST);
    end else if (i_clk_en && acc_wr_nxt) begin
      o_acc <= sum_w; // [RULE_05]
    end
  end
endmodule
`default_nettype wire

// ### verification/sks_mem_model.sv
// Data memory partner: read data one cycle after the strobe, writes on strobe.
// Assumes the bench preloads mem hierarchically.
`timescale 1ns/10ps
`default_nettype none
module sks_mem_model (
  input  wire logic       i_clk_sys, i_rd, i_wr,
  input  wire logic [7:0] i_addr, i_wdata,
  output logic      [7:0] o_rdata
);
  logic [7:0] mem [256];
  logic       rd_r = 1'b0;
  always @(posedge i_clk_sys) begin
    rd_r <= i_rd;
    if (i_rd) o_rdata <= mem[i_addr];
    else if (rd_r) o_rdata <= ~o_rdata; // Inverted once the read slot is over
    if (i_wr) mem[i_addr] <= i_wdata;
  end
endmodule
`default_nettype wire

// ### verification/sks_core_chk.sv
// Timing and result checks on the sks_core ports.
// Assumes i_clk_en is held high.
`timescale 1ns/10ps
`default_nettype none
module sks_core_chk (
  input wire logic i_clk_sys, i_reset, i_op_valid, o_busy, o_mem_rd, o_mem_wr, o_acc_wr, o_skip, o_dummy, o_done,
  input wire logic [1:0] i_opcode,
  input wire logic [7:0] i_mem_rdata, o_mem_wdata, o_acc
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  wire take = i_op_valid && i_opcode != 2'h0 && !o_busy;
  a_read_after_take: assert property (take |=> o_mem_rd && o_busy) else $error("no read");
  a_three_cycles: assert property (o_mem_rd |-> ##2 (o_done || o_dummy)) else $error("length");
  a_skip_dummy: assert property (o_skip |-> o_dummy ##1 o_done) else $error("no dummy");
  a_mem_sum: assert property (o_mem_wr |-> o_mem_wdata == 8'($past(i_mem_rdata) + 8'h01)) else $error("sum");
  a_mem_skip: assert property (o_mem_wr |-> o_skip == (o_mem_wdata == 8'h00)) else $error("mem skip");
  a_no_skip: assert property (o_mem_wr && !o_skip |-> o_done) else $error("no done");
  a_acc_sum: assert property (o_acc_wr |-> !o_mem_wr && o_acc == 8'($past(i_mem_rdata) + 8'h01)) else $error("acc");
  a_acc_skip: assert property (o_acc_wr |-> o_skip == (o_acc == 8'h00)) else $error("acc skip");
  c_mem_skip: cover property (o_mem_wr && o_skip);
  c_acc_skip: cover property (o_acc_wr && o_skip);
  c_bit_skip: cover property (o_skip && !o_mem_wr && !o_acc_wr);
endmodule
bind sks_core sks_core_chk u_chk (.*);
`default_nettype wire

// ### verification/skip_increment_instructions_tb.sv
// Self-checking bench for sks_core.
// Assumes sks_mem_model as the data memory.
`timescale 1ns/10ps
`default_nettype none
module skip_increment_instructions_tb;
  logic i_clk_sys = 0, i_reset = 1, i_clk_en = 1, i_op_valid = 0, sk = 0;
  logic [1:0] i_opcode = 0;
  logic [2:0] i_bit_sel = 0;
  logic [7:0] i_addr = 0, i_mem_rdata, o_mem_addr, o_mem_wdata, o_acc, acc_e = 0, m;
  logic o_busy, o_mem_rd, o_mem_wr, o_acc_wr, o_skip, o_dummy, o_done;
  logic [24:0] q[$], e;
  int mismatches = 0, comparisons = 0;
  logic [31:0] seed = 32'h9;
  always #25 i_clk_sys = ~i_clk_sys;
  sks_core dut (.*);
  sks_mem_model mem (.i_clk_sys, .i_rd(o_mem_rd), .i_wr(o_mem_wr), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata),
    .o_rdata(i_mem_rdata));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task check(input logic [24:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Notes {skip, acc, memory byte, address} and issues one instruction
  task run(input logic [1:0] o, input logic [7:0] a, v, input logic [2:0] b);
    // Let the previous result be compared before memory is preloaded again
    while (q.size() != 0) @(posedge i_clk_sys) #2;
    mem.mem[a] = v;
    m = v + 8'h01;
    if (o == 2'h2) acc_e = m;
    q.push_back({o == 2'h3 ? v[b] : m == 8'h00, acc_e, o == 2'h1 ? m : v, a});
    i_opcode = o;
    i_addr = a;
    i_bit_sel = b;
    i_op_valid = 1;
    @(posedge i_clk_sys) #2 i_op_valid = 0;
    repeat (8) begin
      @(posedge i_clk_sys) #2;
      if (o_done) break;
    end
  endtask
  always @(posedge i_clk_sys) begin
    if (o_skip) sk = 1;
    if (o_done) begin
      #1 e = q.pop_front();
      check({sk, o_acc, mem.mem[e[7:0]], e[7:0]}, e);
      sk = 0;
    end
  end
  initial begin
    #(50 * 1000);
    mismatches++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge i_clk_sys);
    #2 i_reset = 0;
    check(25'({o_busy, o_acc}), 25'h0);
    i_op_valid = 1;
    @(posedge i_clk_sys) #2 i_op_valid = 0;
    @(posedge i_clk_sys) #2 check(25'(o_busy | o_mem_rd), 25'h0);
    $display("test reset and refusal done");
    for (int i = 0; i < 30; i++) run(2'(i % 3 + 1), 8'(rnd()), i[0] ? 8'hff : 8'(rnd()), 3'(rnd()));
    while (q.size() != 0) @(posedge i_clk_sys) #2;
    $display("test random ops done");
    conclude();
  end
endmodule
`default_nettype wire
